// ---- hdl/prx_consts.svh ----
// constants for the peripheral register transfer executor
`ifndef PRX_CONSTS_SVH
`define PRX_CONSTS_SVH
// apb byte offsets
`define PRX_OFF_CMD      12'h000
`define PRX_OFF_ACC      12'h004
`define PRX_OFF_BREG     12'h008
`define PRX_OFF_STAT     12'h00c
`define PRX_OFF_MASK     12'h010
`define PRX_OFF_WAKE     12'h014
`define PRX_OFF_PULL     12'h018
`define PRX_OFF_SER      12'h01c
`define PRX_OFF_CLK      12'h020
`define PRX_OFF_ICTL     12'h024
// field positions
`define PRX_ICTL_SIE_BIT 3
`define PRX_ST_DONE_BIT  0
`define PRX_ST_SKIP_BIT  1
`define PRX_ST_EXEC_BIT  2
// reset values
`define PRX_RST_NIB      4'h0
`define PRX_RST_BYTE     8'h00
`endif

// ---- hdl/prx_exec.sv ----
// peripheral register transfer executor with apb command port
// Behaviour
// - write copies accumulator to wakeup_ctrl_one; read returns it to accumulator
// - write copies accumulator to wakeup_ctrl_two; read loads accumulator from it
// - write stores accumulator to resistor_ctl_zero; read returns it
// - write stores accumulator to resistor_ctl_one; read returns it
// - write stores accumulator to resistor_ctl_two; read returns it
// - write copies accumulator to edge_wakeup_ctl; read returns it
// - serial read: shift high nibble to second register, low to accumulator
// - serial write: high nibble from second register, low from accumulator
// - serial start clears serial_done_flag and launches a transfer
// - serial test skips and clears flag when enable bit zero and flag set
// - with serial_irq_enable_bit set, serial test is a no-operation
// - serial_config_reg moves to accumulator on read, from it on write
// - oscillator select switches main_system_clock source to internal rc
// - only accumulator bit zero is written into osc_stop_ctrl
// - clock_divider_reg moves to accumulator on read, from it on write
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "prx_consts.svh"

module prx_exec
  import prx_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial unit
  input  wire logic        ser_done_in,
  input  wire logic [7:0]  ser_rx_data,
  input  wire logic        ser_rx_load,
  output logic             ser_start,
  output logic      [7:0]  ser_shift,
  // peripheral control outputs
  output logic      [3:0]  wakeup_ctrl_one,
  output logic      [3:0]  wakeup_ctrl_two,
  output logic      [3:0]  resistor_ctl_zero,
  output logic      [3:0]  resistor_ctl_one,
  output logic      [3:0]  resistor_ctl_two,
  output logic      [3:0]  edge_wakeup_ctl,
  output logic      [3:0]  serial_config_reg,
  output logic      [3:0]  clock_divider_reg,
  output logic             osc_stop_ctrl,
  output logic             rc_osc_select,
  output logic             skip_next,
  output logic             carry_flag,
  // interrupt
  output logic             irq
);

  prx_state_t q, d;

  // done input comes from the serial clock domain side: two flops, then a third for rise detect
  logic sync1_q, sync2_q, sync3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= ser_done_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  function automatic logic [31:0] nib(input logic [3:0] v);
    nib = {28'h0000000, v};
  endfunction

  logic    wr_acc, rd_acc;
  prx_op_t op;
  logic    done_rise;
  assign wr_acc    = psel && penable && pwrite;
  assign rd_acc    = psel && penable && !pwrite;
  assign op        = prx_op_t'(pwdata[4:0]);
  assign done_rise = sync2_q && !sync3_q;

  // next-state logic: bus decode, instruction execution, flags
  always_comb begin
    logic exec;
    logic ev_done, ev_skip;
    d       = q;
    exec    = 1'b0;
    ev_done = 1'b0;
    ev_skip = 1'b0;
    d.sstart  = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    // a pending skip drops exactly the next instruction word
    if (wr_acc && !q.pready && paddr == `PRX_OFF_CMD) begin
      if (q.skip) d.skip = 1'b0;
      else exec = 1'b1;
    end
    if (exec) begin
      case (op)
        PRX_OP_TK1A:  d.wk1 = q.acc;
        PRX_OP_TAK1:  d.acc = q.wk1;
        PRX_OP_TK2A:  d.wk2 = q.acc;
        PRX_OP_TAK2:  d.acc = q.wk2;
        PRX_OP_TPU0A: d.pu0 = q.acc;
        PRX_OP_TAPU0: d.acc = q.pu0;
        PRX_OP_TPU1A: d.pu1 = q.acc;
        PRX_OP_TAPU1: d.acc = q.pu1;
        PRX_OP_TPU2A: d.pu2 = q.acc;
        PRX_OP_TAPU2: d.acc = q.pu2;
        PRX_OP_TL1A:  d.ewk = q.acc;
        PRX_OP_TAL1:  d.acc = q.ewk;
        PRX_OP_SRDAB: begin
          d.breg = q.sreg[7:4];
          d.acc  = q.sreg[3:0];
        end
        PRX_OP_SWRAB: d.sreg = {q.breg, q.acc};
        PRX_OP_SST: begin
          d.done   = 1'b0;
          d.sstart = 1'b1;
        end
        PRX_OP_SNZ: begin
          if (!q.ictl[`PRX_ICTL_SIE_BIT] && q.done) begin
            d.done  = 1'b0;
            d.skip  = 1'b1;
            ev_skip = 1'b1;
          end
        end
        PRX_OP_RDCFG: d.acc   = q.scfg;
        PRX_OP_WRCFG: d.scfg  = q.acc;
        PRX_OP_RCSEL: d.rcsel = 1'b1;
        PRX_OP_WRSTP: d.ostop = q.acc[0];
        PRX_OP_RDDIV: d.acc   = q.div;
        PRX_OP_WRDIV: d.div   = q.acc;
        default: ;
      endcase
    end
    // serial unit delivers received byte and completion; set wins
    if (ser_rx_load) d.sreg = ser_rx_data;
    if (done_rise) begin
      d.done  = 1'b1;
      ev_done = 1'b1;
    end
    // register writes other than commands
    if (wr_acc && !q.pready) begin
      case (paddr)
        `PRX_OFF_ACC:  d.acc  = pwdata[3:0];
        `PRX_OFF_BREG: d.breg = pwdata[3:0];
        `PRX_OFF_ICTL: d.ictl = pwdata[3:0];
        `PRX_OFF_MASK: d.mask = pwdata[2:0];
        `PRX_OFF_STAT: d.stat = q.stat & ~pwdata[2:0];
        `PRX_OFF_CMD:  ;
        default:       d.pslverr = 1'b1;
      endcase
      d.pready = 1'b1;
    end
    // sticky events: set beats clear
    if (ev_done) d.stat[`PRX_ST_DONE_BIT] = 1'b1;
    if (ev_skip) d.stat[`PRX_ST_SKIP_BIT] = 1'b1;
    if (exec)    d.stat[`PRX_ST_EXEC_BIT] = 1'b1;
    // reads
    if (rd_acc && !q.pready) begin
      d.pready = 1'b1;
      case (paddr)
        `PRX_OFF_CMD:  d.prdata = {26'h0, q.rcsel, q.ostop, q.skip,
                                   q.done, q.carry, 1'b0};
        `PRX_OFF_ACC:  d.prdata = nib(q.acc);
        `PRX_OFF_BREG: d.prdata = nib(q.breg);
        `PRX_OFF_STAT: d.prdata = {29'h0, q.stat};
        `PRX_OFF_MASK: d.prdata = {29'h0, q.mask};
        `PRX_OFF_WAKE: d.prdata = {20'h0, q.ewk, q.wk2, q.wk1};
        `PRX_OFF_PULL: d.prdata = {20'h0, q.pu2, q.pu1, q.pu0};
        `PRX_OFF_SER:  d.prdata = {20'h0, q.scfg, q.sreg};
        `PRX_OFF_CLK:  d.prdata = {27'h0, q.ostop, q.div};
        `PRX_OFF_ICTL: d.prdata = nib(q.ictl);
        default: begin
          d.prdata  = 32'h00000000;
          d.pslverr = 1'b1;
        end
      endcase
    end
    d.irq = |(d.stat & d.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign ser_start         = q.sstart;
  assign ser_shift         = q.sreg;
  assign wakeup_ctrl_one   = q.wk1;
  assign wakeup_ctrl_two   = q.wk2;
  assign resistor_ctl_zero = q.pu0;
  assign resistor_ctl_one  = q.pu1;
  assign resistor_ctl_two  = q.pu2;
  assign edge_wakeup_ctl   = q.ewk;
  assign serial_config_reg = q.scfg;
  assign clock_divider_reg = q.div;
  assign osc_stop_ctrl     = q.ostop;
  assign rc_osc_select     = q.rcsel;
  assign skip_next         = q.skip;
  assign carry_flag        = q.carry;
  assign irq               = q.irq;

endmodule
`default_nettype wire

// ---- hdl/prx_pkg.sv ----
// types for the peripheral register transfer executor
package prx_pkg;
  typedef enum logic [4:0] {
    PRX_OP_NOP   = 5'h00,
    PRX_OP_TK1A  = 5'h01, PRX_OP_TAK1  = 5'h02,
    PRX_OP_TK2A  = 5'h03, PRX_OP_TAK2  = 5'h04,
    PRX_OP_TPU0A = 5'h05, PRX_OP_TAPU0 = 5'h06,
    PRX_OP_TPU1A = 5'h07, PRX_OP_TAPU1 = 5'h08,
    PRX_OP_TPU2A = 5'h09, PRX_OP_TAPU2 = 5'h0a,
    PRX_OP_TL1A  = 5'h0b, PRX_OP_TAL1  = 5'h0c,
    PRX_OP_SRDAB = 5'h0d, PRX_OP_SWRAB = 5'h0e,
    PRX_OP_SST   = 5'h0f, PRX_OP_SNZ   = 5'h10,
    PRX_OP_RDCFG = 5'h11, PRX_OP_WRCFG = 5'h12,
    PRX_OP_RCSEL = 5'h13, PRX_OP_WRSTP = 5'h14,
    PRX_OP_RDDIV = 5'h15, PRX_OP_WRDIV = 5'h16
  } prx_op_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] breg;
    logic       carry;
    logic [3:0] wk1;
    logic [3:0] wk2;
    logic [3:0] pu0;
    logic [3:0] pu1;
    logic [3:0] pu2;
    logic [3:0] ewk;
    logic [7:0] sreg;
    logic [3:0] scfg;
    logic [3:0] div;
    logic [3:0] ictl;
    logic       ostop;
    logic       rcsel;
    logic       done;
    logic       sstart;
    logic       skip;
    logic [2:0] stat;
    logic [2:0] mask;
    logic       irq;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
  } prx_state_t;
endpackage

// ---- test/prx_exec_sva.sv ----
// assertions on the executor ports
`timescale 1ns/1ps
`default_nettype none
module prx_exec_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  // serial and control
  input wire logic        ser_rx_load,
  input wire logic [7:0]  ser_rx_data,
  input wire logic        ser_start,
  input wire logic [7:0]  ser_shift,
  input wire logic [3:0]  wakeup_ctrl_one,
  input wire logic        rc_osc_select,
  input wire logic        skip_next,
  input wire logic        carry_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // handshake, flags and transfers
  chk_one_wait: assert property (
    psel && penable && clk_en && !pready |=> pready) else $error("late");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("ready held");
  chk_carry_zero: assert property (
    carry_flag == 1'b0) else $error("carry moved");
  chk_rc_sticky: assert property (
    rc_osc_select |=> rc_osc_select) else $error("rc dropped");
  chk_start_pulse: assert property (
    ser_start |=> !ser_start) else $error("start held");
  chk_rx_load: assert property (
    ser_rx_load && clk_en |=> ser_shift == $past(ser_rx_data))
    else $error("shift not loaded");
  chk_wake_write: assert property (
    $changed(wakeup_ctrl_one) |-> pready && $past(psel && penable && pwrite))
    else $error("wake moved");
  chk_skip_once: assert property (
    skip_next && psel && penable && pwrite && !pready && clk_en &&
    paddr == 12'h000 |=> !skip_next)
    else $error("skip kept");
  // main scenarios
  cover property (ser_start);
  cover property ($rose(skip_next));
  cover property (ser_rx_load);
endmodule
bind prx_exec prx_exec_sva u_sva (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pready, .ser_rx_load, .ser_rx_data,
  .ser_start, .ser_shift, .wakeup_ctrl_one, .rc_osc_select, .skip_next,
  .carry_flag);
`default_nettype wire

// ---- test/prx_serial_model.sv ----
// serial unit stand-in answering a start after a delay
`timescale 1ns/1ps
`default_nettype none
module prx_serial_model #(
  parameter int LAT = 4
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // serial unit side
  input  wire logic       ser_start,
  output logic            ser_done_in,
  output logic      [7:0] ser_rx_data,
  output logic            ser_rx_load
);
  int cnt;
  // a start drops done, then data is loaded and done raised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      ser_done_in <= 1'b0;
      ser_rx_data <= 8'h00;
      ser_rx_load <= 1'b0;
    end else begin
      ser_rx_load <= (cnt == 1);
      ser_rx_data <= (cnt == 1) ? 8'ha5 : ~ser_rx_data; // junk when idle
      if (ser_start) begin
        cnt <= LAT;
        ser_done_in <= 1'b0;
      end else if (cnt != 0) cnt <= cnt - 1;
      if (cnt == 1) ser_done_in <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
`include "prx_consts.svh"
module testbench
  import prx_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic [7:0]  ser_rx_data, ser_shift;
  logic [3:0]  wk1, wk2, pu0, pu1, pu2, ewk, scfg, cdiv;
  logic        skp;
  logic        pready, pslverr, ser_start, ser_done_in, ser_rx_load, irq;
  logic        osc, rc, carry, re;
  int          err_count = 0, n_checks = 0;
  // clock, design and serial stand-in
  always #10 pclk = ~pclk;
  prx_exec dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ser_done_in,
    .ser_rx_data, .ser_rx_load, .ser_start, .ser_shift,
    .wakeup_ctrl_one(wk1), .wakeup_ctrl_two(wk2), .resistor_ctl_zero(pu0),
    .resistor_ctl_one(pu1), .resistor_ctl_two(pu2), .edge_wakeup_ctl(ewk),
    .serial_config_reg(scfg), .clock_divider_reg(cdiv), .osc_stop_ctrl(osc),
    .rc_osc_select(rc), .skip_next(skp), .carry_flag(carry), .irq);
  prx_serial_model u_ser (.pclk, .presetn, .ser_start, .ser_done_in,
    .ser_rx_data, .ser_rx_load);
  // verdict
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, data taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic op(input prx_op_t o);
    apb(1'b1, `PRX_OFF_CMD, {27'h0, o});
  endtask
  task automatic wacc(input logic [3:0] v);
    apb(1'b1, `PRX_OFF_ACC, {28'h0, v});
  endtask
  // each pair written, accumulator cleared, then read back
  task automatic t_xfer;
    prx_op_t wo[8] = '{PRX_OP_TK1A, PRX_OP_TK2A, PRX_OP_TPU0A, PRX_OP_TPU1A,
                       PRX_OP_TPU2A, PRX_OP_TL1A, PRX_OP_WRCFG, PRX_OP_WRDIV};
    for (int k = 0; k < 8; k++) begin
      wacc(4'(k + 3));
      op(wo[k]);
      wacc(4'h0);
      op(prx_op_t'(k < 6 ? wo[k] + 5'h1 : wo[k] - 5'h1));
      apb(1'b0, `PRX_OFF_ACC, 32'h0);
      chk(rq, 32'(k + 3));
    end
    chk({28'h0, wk1}, 32'h3);
    chk({8'h0, ewk, pu2, pu1, pu0, wk2, wk1}, 32'h876543);
    chk({24'h0, scfg, cdiv}, 32'h9a);
  endtask
  // serial write, start, completion interrupt and read
  task automatic t_serial;
    apb(1'b1, `PRX_OFF_BREG, 32'hc);
    wacc(4'h3);
    op(PRX_OP_SWRAB);
    @(posedge pclk);
    chk({24'h0, ser_shift}, 32'hc3);
    apb(1'b1, `PRX_OFF_MASK, 32'h1);
    op(PRX_OP_SST);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    op(PRX_OP_SRDAB);
    apb(1'b0, `PRX_OFF_ACC, 32'h0);
    chk(rq, 32'h5);
    apb(1'b0, `PRX_OFF_BREG, 32'h0);
    chk(rq, 32'ha);
    apb(1'b1, `PRX_OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  // serial test with enable set, then clear, then the dropped word
  task automatic t_snz;
    apb(1'b1, `PRX_OFF_ICTL, 32'h8);
    op(PRX_OP_SNZ);
    apb(1'b0, `PRX_OFF_CMD, 32'h0);
    chk(rq & 32'hc, 32'h4);
    apb(1'b1, `PRX_OFF_ICTL, 32'h0);
    op(PRX_OP_SNZ);
    apb(1'b0, `PRX_OFF_CMD, 32'h0);
    chk(rq & 32'hc, 32'h8);
    chk({31'h0, skp}, 32'h1);
    wacc(4'h9);
    op(PRX_OP_TK1A);
    @(posedge pclk);
    chk({28'h0, wk1}, 32'h3);
    chk({31'h0, skp}, 32'h0);
    op(PRX_OP_TK1A);
    @(posedge pclk);
    chk({28'h0, wk1}, 32'h9);
  endtask
  // oscillator controls, carry and a refused address
  task automatic t_clock;
    wacc(4'h1);
    op(PRX_OP_WRSTP);
    op(PRX_OP_RCSEL);
    @(posedge pclk);
    chk({30'h0, rc, osc}, 32'h3);
    wacc(4'he);
    op(PRX_OP_WRSTP);
    @(posedge pclk);
    chk({30'h0, carry, osc}, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({rq[30:0], re}, 32'h1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_xfer();
    t_serial();
    t_snz();
    t_clock();
    close_out();
  end
endmodule
`default_nettype wire
